/* rtl/frame_ring_error_handler.sv */
/*
  Ring error handler: sticky status flags, per-ring state on entry errors,
  host parity screening, and transmit and receive error indications.
  Assumes all event inputs are one-cycle strobes from logic on clk_in.
*/
//
// Function
// - Tx data parity error stops frame fetch at once, frame marked bad.
// - Tx parity error on a frame being sent aborts its transmission.
// - Frame error indication is written back; ring otherwise continues.
// - Descriptor parity error stops transfer, no FIFO load, pointer held.
// - Descriptor parity error sets ring Empty and its parity flag.
// - Descriptor parity error sets not-ready and fault flags, interrupting.
// - Host access with bad parity is ignored, except for the two effects below.
// - Host write with bad parity sets host parity flag.
// - Bad-parity command extension write discards following command.
// - Ring parity flag set on entry read parity error, cleared on redefine/ready.
// - Ring op flag set on port fault or first/last error, same clears.
// - Internal operation error flag is sticky until host clears it.
// - Per-ring overrun flag sticky until host writes general status.
// - Ring fault flag set by parity, port fault or first/last error.
// - Destination ring flag set by parity or port fault there.
// - Mac side tx parity sets tx memory parity flag.
// - Tx port error code reports parity failures as 010, 110 or 111.
// - Underrun sets starve flag, drops only the current frame.
// - Killed without starve or parity means abort by mac_tx_kill.
// - Rx error indication on bad frame in receive-all, abort, long fragment.
`timescale 1ns/1ps
`include "frame_ring_error_handler_consts.svh"

module frame_ring_error_handler (
	input wire logic clk_in, // 125 MHz clock
	input wire logic rst_in, // Async reset, high
	input wire logic [4:0] addr_in, // Register word index
	input wire logic [15:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	input wire logic host_par_err_in, // Bad parity on this access
	output logic [15:0] rdata_out, // Read data, cycle after rd_in
	input wire logic tx_par_err_in, // Port parity error on tx fetch
	input wire logic tx_sending_in, // Current frame is on the line
	input wire logic tx_starve_in, // Underrun on current frame
	input wire logic mac_tx_kill_in, // Abort request from the mac
	input wire logic port_op_tx_in, // Port op fault on tx data
	input wire logic tx_frame_end_in, // Current frame finished
	input wire logic mac_tx_par_in, // Mac side parity on tx data
	input wire logic [2:0] ring_idx_in, // Ring of the entry error
	input wire logic ring_par_in, // Parity error on entry read
	input wire logic port_op_fault_in, // Port op fault on entry read
	input wire logic first_last_err_in, // First/last bit error
	input wire logic dest_par_in, // Parity on destination entry
	input wire logic dest_op_in, // Port fault on destination entry
	input wire logic int_op_err_in, // Internal operation error
	input wire logic rx_port_a_par_in, // Rx parity, port a
	input wire logic rx_port_b_par_in, // Rx parity, port b
	input wire logic [1:0] overrun_in, // Overrun on rings 4 and 5
	input wire logic rx_end_in, // Rx frame or fragment ended
	input wire logic rx_bad_frame_in, // Error or secondary frame
	input wire logic rx_abort_in, // Rx operation aborted
	input wire logic rx_frag_in, // Ended item is a fragment
	input wire logic [11:0] rx_len_in, // Length of ended item
	output logic irq_out, // Interrupt request
	output logic tx_err_frame_out, // Stop fetch, frame is bad
	output logic tx_abort_out, // Abort transmission pulse
	output logic tx_ind_valid_out, // Tx indication write pulse
	output frame_ring_error_handler_pkg::tx_ind_type tx_ind_out, // Tx ind
	output logic entry_halt_out, // Entry dropped, pointer held
	output logic [2:0] entry_halt_ring_out, // Ring of dropped entry
	output logic [7:0] ring_ready_out, // Ring may fetch
	output logic rx_ind_valid_out, // Rx error indication pulse
	output frame_ring_error_handler_pkg::rx_ind_type rx_ind_out // Rx ind
);

	// ------------------------------------------------------------------
	// Host access decode
	// ------------------------------------------------------------------
	logic [`GEN_W-1:0] gen_status;
	logic [`GEN_W-1:0] gen_mask;
	logic sec_status;
	logic sec_mask;
	logic [3:0] int_fault;
	logic [15:0] cmd_ext;
	logic cmd_ext_bad;
	logic [15:0] rx_cfg;
	frame_ring_error_handler_pkg::ring_state_type ring_state [`RING_N];
	logic [`RING_N-1:0] ring_par;
	logic [`RING_N-1:0] ring_op;
	logic good_wr;
	logic entry_err;
	logic [`GEN_W-1:0] gen_clr;
	logic [`GEN_W-1:0] gen_set;
	logic [3:0] int_clr;
	logic [3:0] int_set;
	logic cmd_go;
	logic ready_go;
	logic [2:0] cmd_ring;
	logic [2:0] ready_ring;
	frame_ring_error_handler_pkg::cmd_type cmd_code;

	// Writes with bad parity reach no register but the host parity flag and cmd_ext_bad
	assign good_wr = wr_in && !host_par_err_in;
	assign entry_err = ring_par_in || port_op_fault_in || first_last_err_in;
	assign cmd_ring = cmd_ext[2:0];
	assign ready_ring = wdata_in[2:0];
	assign cmd_code = frame_ring_error_handler_pkg::cmd_type'(wdata_in[3:0]);
	assign cmd_go = good_wr && addr_in == `REG_CMD && !cmd_ext_bad;
	assign ready_go = good_wr && addr_in == `REG_FUNC_CTRL &&
		wdata_in[`FCR_READY];

	// ------------------------------------------------------------------
	// General status flags
	// ------------------------------------------------------------------
	// Write one to clear; a set arriving in the same cycle wins
	always_comb begin
		gen_clr = '0;
		if (good_wr && addr_in == `REG_GEN_STATUS) begin
			gen_clr = wdata_in[`GEN_W-1:0];
		end
		gen_set = '0;
		gen_set[`GEN_NOT_READY] = entry_err;
		gen_set[`GEN_RING_FAULT] = entry_err;
		gen_set[`GEN_HOST_PAR] = wr_in && host_par_err_in;
		gen_set[`GEN_INT_OP] = int_op_err_in;
		gen_set[`GEN_OVR4] = overrun_in[0];
		gen_set[`GEN_OVR5] = overrun_in[1];
	end

	// Sticky until the host writes them clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gen_status <= '0;
		end else begin
			gen_status <= (gen_status & ~gen_clr) | gen_set;
		end
	end

	// Secondary status, destination ring errors
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sec_status <= 1'b0;
		end else if (dest_par_in || dest_op_in) begin
			sec_status <= 1'b1;
		end else if (good_wr && addr_in == `REG_SEC_STATUS &&
			wdata_in[`SEC_DEST_PAR]) begin
			sec_status <= 1'b0;
		end
	end

	// Internal fault register, write one to clear
	always_comb begin
		int_clr = '0;
		if (good_wr && addr_in == `REG_INT_FAULT) begin
			int_clr = wdata_in[3:0];
		end
		int_set = '0;
		int_set[`INT_TX_MEM] = mac_tx_par_in;
		int_set[`INT_RX_A] = rx_port_a_par_in;
		int_set[`INT_RX_B] = rx_port_b_par_in;
		int_set[`INT_OP] = int_op_err_in;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_fault <= '0;
		end else begin
			int_fault <= (int_fault & ~int_clr) | int_set;
		end
	end

	// ------------------------------------------------------------------
	// Plain control registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			gen_mask <= '0;
			sec_mask <= 1'b0;
			cmd_ext <= `RST_16;
			rx_cfg <= `RST_CFG;
		end else if (good_wr) begin
			case (addr_in)
				`REG_GEN_MASK: gen_mask <= wdata_in[`GEN_W-1:0];
				`REG_SEC_MASK: sec_mask <= wdata_in[`SEC_DEST_PAR];
				`REG_CMD_EXT: cmd_ext <= wdata_in;
				`REG_RX_CFG: rx_cfg <= wdata_in;
				default: ;
			endcase
		end
	end

	// A corrupted extension poisons only the next command write
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_ext_bad <= 1'b0;
		end else if (wr_in && addr_in == `REG_CMD_EXT) begin
			cmd_ext_bad <= host_par_err_in;
		end else if (good_wr && addr_in == `REG_CMD) begin
			cmd_ext_bad <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Per-ring state
	// ------------------------------------------------------------------
	// Entry errors are applied last so they win over host actions
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < `RING_N; i++) begin
				ring_state[i] <= frame_ring_error_handler_pkg::RING_STOPPED;
			end
			ring_par <= '0;
			ring_op <= '0;
		end else begin
			if (ready_go) begin
				ring_state[ready_ring] <=
					frame_ring_error_handler_pkg::RING_READY;
				ring_par[ready_ring] <= 1'b0;
				ring_op[ready_ring] <= 1'b0;
			end
			if (cmd_go && cmd_code == frame_ring_error_handler_pkg::CMD_STOP)
				begin
				ring_state[cmd_ring] <=
					frame_ring_error_handler_pkg::RING_STOPPED;
			end
			if (cmd_go &&
				cmd_code == frame_ring_error_handler_pkg::CMD_REDEFINE) begin
				ring_state[cmd_ring] <=
					frame_ring_error_handler_pkg::RING_STOPPED;
				ring_par[cmd_ring] <= 1'b0;
				ring_op[cmd_ring] <= 1'b0;
			end
			if (entry_err) begin
				ring_state[ring_idx_in] <=
					frame_ring_error_handler_pkg::RING_EMPTY;
			end
			if (ring_par_in) begin
				ring_par[ring_idx_in] <= 1'b1;
			end
			if (port_op_fault_in || first_last_err_in) begin
				ring_op[ring_idx_in] <= 1'b1;
			end
		end
	end

	// Fetch enable per ring and entry drop notice
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ring_ready_out <= '0;
			entry_halt_out <= 1'b0;
			entry_halt_ring_out <= '0;
		end else begin
			for (int i = 0; i < `RING_N; i++) begin
				ring_ready_out[i] <= ring_state[i] ==
					frame_ring_error_handler_pkg::RING_READY;
			end
			entry_halt_out <= entry_err;
			entry_halt_ring_out <= ring_idx_in;
		end
	end

	// ------------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------------
	// Bad-parity reads return zero and touch nothing
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= `RST_16;
		end else if (rd_in && !host_par_err_in) begin
			case (addr_in)
				`REG_GEN_STATUS: rdata_out <= {10'h000, gen_status};
				`REG_GEN_MASK: rdata_out <= {10'h000, gen_mask};
				`REG_SEC_STATUS: rdata_out <= {15'h0000, sec_status};
				`REG_SEC_MASK: rdata_out <= {15'h0000, sec_mask};
				`REG_INT_FAULT: rdata_out <= {12'h000, int_fault};
				`REG_CMD_EXT: rdata_out <= cmd_ext;
				`REG_RX_CFG: rdata_out <= rx_cfg;
				default: begin
					if (addr_in[4]) begin
						rdata_out <= {12'h000, ring_op[addr_in[2:0]],
							ring_par[addr_in[2:0]],
							ring_state[addr_in[2:0]]};
					end else begin
						rdata_out <= `RST_16;
					end
				end
			endcase
		end else begin
			rdata_out <= `RST_16;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(gen_status & gen_mask) ||
				(sec_status && sec_mask);
		end
	end

	// ------------------------------------------------------------------
	// Transmit frame errors
	// ------------------------------------------------------------------
	logic tx_par;
	logic tx_par_line;
	logic tx_op;
	logic tx_starve;
	logic tx_kill;
	logic now_par;
	logic now_line;
	logic now_op;
	logic now_starve;
	logic now_kill;

	// Include events of the closing cycle in the indication
	assign now_par = tx_par || tx_par_err_in;
	assign now_line = tx_par_line || (tx_par_err_in && tx_sending_in);
	assign now_op = tx_op || port_op_tx_in;
	assign now_starve = tx_starve || tx_starve_in;
	assign now_kill = tx_kill || mac_tx_kill_in;

	// Error memory for the current frame only; cleared at its end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_par <= 1'b0;
			tx_par_line <= 1'b0;
			tx_op <= 1'b0;
			tx_starve <= 1'b0;
			tx_kill <= 1'b0;
		end else if (tx_frame_end_in) begin
			tx_par <= 1'b0;
			tx_par_line <= 1'b0;
			tx_op <= 1'b0;
			tx_starve <= 1'b0;
			tx_kill <= 1'b0;
		end else begin
			tx_par <= now_par;
			tx_par_line <= now_line;
			tx_op <= now_op;
			tx_starve <= now_starve;
			tx_kill <= now_kill;
		end
	end

	// Fetch stops at once and stays stopped until the frame ends
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_err_frame_out <= 1'b0;
			tx_abort_out <= 1'b0;
		end else begin
			tx_err_frame_out <= !tx_frame_end_in &&
				(now_par || now_starve);
			tx_abort_out <= (tx_par_err_in && tx_sending_in) ||
				tx_starve_in;
		end
	end

	// One indication per frame; nothing else on the ring is held up
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_ind_valid_out <= 1'b0;
			tx_ind_out <= '0;
		end else begin
			tx_ind_valid_out <= tx_frame_end_in;
			if (tx_frame_end_in) begin
				if (now_par && now_op) begin
					tx_ind_out.port_err_code <= `PER_PORT_OP;
				end else if (now_line) begin
					tx_ind_out.port_err_code <= `PER_SENDING;
				end else if (now_par) begin
					tx_ind_out.port_err_code <= `PER_FETCH;
				end else begin
					tx_ind_out.port_err_code <= `PER_NONE;
				end
				tx_ind_out.tx_killed_flag <= now_line || now_starve ||
					now_kill;
				tx_ind_out.tx_starve_flag <= now_starve;
				tx_ind_out.parity_fault_flag <= now_par;
			end
		end
	end

	// ------------------------------------------------------------------
	// Receive error indication
	// ------------------------------------------------------------------
	logic rx_par;
	logic rx_long;
	logic rx_bad;

	assign rx_long = rx_frag_in && rx_len_in > rx_cfg[11:0];
	assign rx_bad = rx_bad_frame_in && rx_cfg[`CFG_RX_ALL];

	// Port parity seen while the item was moved out
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_par <= 1'b0;
		end else if (rx_end_in) begin
			rx_par <= 1'b0;
		end else if (rx_port_a_par_in || rx_port_b_par_in) begin
			rx_par <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_ind_valid_out <= 1'b0;
			rx_ind_out <= '0;
		end else begin
			rx_ind_valid_out <= rx_end_in &&
				(rx_bad || rx_abort_in || rx_long);
			rx_ind_out <= {rx_bad, rx_abort_in, rx_long,
				rx_par || rx_port_a_par_in || rx_port_b_par_in};
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	host_ignore_a: assert property (
		wr_in && host_par_err_in && addr_in == `REG_GEN_MASK |=>
		gen_mask == $past(gen_mask))
		else $error("bad parity write changed the mask");

	host_flag_a: assert property (
		wr_in && host_par_err_in |=> gen_status[`GEN_HOST_PAR])
		else $error("host parity flag not set");

	desc_empty_a: assert property (
		ring_par_in |=> ring_state[$past(ring_idx_in)] ==
		frame_ring_error_handler_pkg::RING_EMPTY &&
		ring_par[$past(ring_idx_in)])
		else $error("ring not empty with parity flag");

	ring_flags_a: assert property (
		entry_err |=> gen_status[`GEN_NOT_READY] &&
		gen_status[`GEN_RING_FAULT] ##1 entry_halt_out == 1'b0 ||
		$past(entry_err))
		else $error("ring flags not set");

	tx_abort_a: assert property (
		tx_par_err_in && tx_sending_in |=> tx_abort_out &&
		tx_err_frame_out || $past(tx_frame_end_in))
		else $error("sending frame not aborted");

	tx_code_a: assert property (
		tx_ind_valid_out && tx_ind_out.parity_fault_flag |->
		tx_ind_out.port_err_code inside {`PER_FETCH, `PER_SENDING,
		`PER_PORT_OP})
		else $error("parity indication without code");

	kill_only_a: assert property (
		tx_frame_end_in && !now_par && !now_starve && !now_line &&
		now_kill |=> tx_ind_valid_out && tx_ind_out.tx_killed_flag &&
		!tx_ind_out.tx_starve_flag && !tx_ind_out.parity_fault_flag)
		else $error("kill indication wrong");

	irq_tie_a: assert property (
		|(gen_status & gen_mask) |=> irq_out)
		else $error("enabled flag without interrupt");

endmodule

/* rtl/frame_ring_error_handler_consts.svh */
/*
  Constants of the ring error handler: register indexes, field positions,
  reset values and error codes.
  Assumes a 16-bit register port with a 5-bit word address.
*/
`ifndef FRAME_RING_ERROR_HANDLER_CONSTS_SVH
`define FRAME_RING_ERROR_HANDLER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------------
`define REG_GEN_STATUS 5'h00
`define REG_GEN_MASK 5'h01
`define REG_SEC_STATUS 5'h02
`define REG_SEC_MASK 5'h03
`define REG_INT_FAULT 5'h04
`define REG_CMD_EXT 5'h05
`define REG_CMD 5'h06
`define REG_FUNC_CTRL 5'h07
`define REG_RX_CFG 5'h08
`define REG_RING_BASE 5'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GEN_NOT_READY 0
`define GEN_RING_FAULT 1
`define GEN_HOST_PAR 2
`define GEN_INT_OP 3
`define GEN_OVR4 4
`define GEN_OVR5 5
`define SEC_DEST_PAR 0
`define INT_TX_MEM 0
`define INT_RX_A 1
`define INT_RX_B 2
`define INT_OP 3
`define RSR_PAR 2
`define RSR_OP 3
`define FCR_READY 4
`define CFG_RX_ALL 15

// ----------------------------------------------------------------------
// Widths, reset values and codes
// ----------------------------------------------------------------------
`define GEN_W 6
`define RING_N 8
`define RST_16 16'h0000
`define RST_CFG 16'h0FFF
`define PER_NONE 3'h0
`define PER_FETCH 3'h2
`define PER_SENDING 3'h6
`define PER_PORT_OP 3'h7

`endif

/* rtl/frame_ring_error_handler_pkg.sv */
/*
  Types of the ring error handler: ring states, commands and indications.
  Assumes the constants header is included by the design file.
*/
package frame_ring_error_handler_pkg;

	// Ring state as kept per ring
	typedef enum logic [1:0] {
		RING_STOPPED = 2'b00,
		RING_READY = 2'b01,
		RING_EMPTY = 2'b10
	} ring_state_type;

	// Command codes accepted by the command register
	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_STOP = 4'b0001,
		CMD_REDEFINE = 4'b0010
	} cmd_type;

	// Transmit indication written back to the descriptor ring
	typedef struct packed {
		logic [2:0] port_err_code;
		logic tx_killed_flag;
		logic tx_starve_flag;
		logic parity_fault_flag;
	} tx_ind_type;

	// Receive error indication and its cause
	typedef struct packed {
		logic bad_frame;
		logic aborted;
		logic long_fragment;
		logic parity_fault_flag;
	} rx_ind_type;

endpackage

/* dv/tx_port_model.sv */
/*
  Transmit-side partner: plays the port and mac strobes of one frame.
  Assumes go_in is a one-cycle pulse; mode picks the fault in the frame.
*/
`timescale 1ns/1ps
module tx_port_model (
	input wire logic clk_in, // Bench clock
	input wire logic go_in, // Start one frame
	input wire logic [2:0] mode_in, // Fault kind of the frame
	output logic sending_out, // Frame on the line
	output logic par_out, // Port parity pulse
	output logic starve_out, // Underrun pulse
	output logic kill_out, // Mac abort pulse
	output logic op_out, // Port op fault pulse
	output logic end_out // Frame end pulse
);
	logic [1:0] step = 0;
	initial {sending_out, par_out, starve_out, kill_out, op_out, end_out} = 0;

	// Fault strobes in the first cycle, frame end two cycles later
	// Each strobe is written once per edge, so no pulse is lost to a race
	always @(posedge clk_in) begin
		par_out <= go_in && mode_in < 3;
		op_out <= go_in && mode_in == 2;
		starve_out <= go_in && mode_in == 3;
		kill_out <= go_in && mode_in == 4;
		end_out <= !go_in && step == 1;
		if (go_in) begin
			sending_out <= mode_in == 1 || mode_in > 2;
			step <= 2;
		end else if (step == 1) begin
			sending_out <= 0;
			step <= 0;
		end else if (step != 0) begin
			step <= step - 1;
		end
	end
endmodule

/* dv/test_frame_ring_error_handler.sv */
/*
  Bench for the ring error handler: registers, entry faults, tx and rx.
  Assumes the package, the design and the tx port model are compiled.
*/
`timescale 1ns/1ps
module test_frame_ring_error_handler;
	logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, hpe = 0, go = 0;
	logic [4:0] addr = 0;
	logic [15:0] wdata = 0, rdata;
	logic [10:0] ev = 0;
	logic [2:0] ridx = 0, mode = 0, hring, r;
	logic [3:0] rxq = 0;
	logic [11:0] rlen = 0, wm;
	logic [7:0] rdy;
	logic irq, txe, txa, tv, hlt, rv, snd, tp, tst, tk, top, tend;
	logic rd_seen = 0;
	frame_ring_error_handler_pkg::tx_ind_type ti;
	frame_ring_error_handler_pkg::rx_ind_type ri;
	logic [15:0] rq[$], tq[$], xq[$], hq[$];
	logic [5:0] te[5] = '{6'h11, 6'h35, 6'h39, 6'h06, 6'h04};
	int errors = 0, comparisons = 0, cyc = 0, na = 0, ne = 0;

	always #4 clk = ~clk;

	tx_port_model partner (.clk_in(clk), .go_in(go), .mode_in(mode),
		.sending_out(snd), .par_out(tp), .starve_out(tst),
		.kill_out(tk), .op_out(top), .end_out(tend));

	frame_ring_error_handler dut (.clk_in(clk), .rst_in(rst),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s),
		.host_par_err_in(hpe), .rdata_out(rdata), .tx_par_err_in(tp),
		.tx_sending_in(snd), .tx_starve_in(tst), .mac_tx_kill_in(tk),
		.port_op_tx_in(top), .tx_frame_end_in(tend),
		.mac_tx_par_in(ev[10]), .ring_idx_in(ridx), .ring_par_in(ev[0]),
		.port_op_fault_in(ev[1]), .first_last_err_in(ev[2]),
		.dest_par_in(ev[3]), .dest_op_in(ev[4]), .int_op_err_in(ev[5]),
		.rx_port_a_par_in(ev[6]), .rx_port_b_par_in(ev[7]),
		.overrun_in(ev[9:8]), .rx_end_in(rxq[0]),
		.rx_bad_frame_in(rxq[3]), .rx_abort_in(rxq[2]),
		.rx_frag_in(rxq[1]), .rx_len_in(rlen), .irq_out(irq),
		.tx_err_frame_out(txe), .tx_abort_out(txa),
		.tx_ind_valid_out(tv), .tx_ind_out(ti), .entry_halt_out(hlt),
		.entry_halt_ring_out(hring), .ring_ready_out(rdy),
		.rx_ind_valid_out(rv), .rx_ind_out(ri));

	task automatic cmp(input string n, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Register port master; the read note is taken by the watcher
	task automatic wr(input logic [4:0] a, input logic [15:0] d,
		input logic bad);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		hpe <= bad;
		wr_s <= 1;
		@(posedge clk);
		wr_s <= 0;
		hpe <= 0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e,
		input logic bad);
		rq.push_back(e);
		@(posedge clk);
		addr <= a;
		hpe <= bad;
		rd_s <= 1;
		@(posedge clk);
		rd_s <= 0;
		hpe <= 0;
	endtask

	task automatic pulse(input logic [10:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 0;
	endtask

	task automatic rxe(input logic [3:0] q, input logic [11:0] l,
		input logic [3:0] e, input logic due);
		if (due) xq.push_back(e);
		@(posedge clk);
		rxq <= q;
		rlen <= l;
		@(posedge clk);
		rxq <= 0;
	endtask

	// Watcher: each read, indication or halt retires the oldest note of its kind; abort pulses and err-frame cycles are only counted
	always @(posedge clk) begin
		if (rd_seen) cmp("rdata", rq.pop_front(), rdata);
		if (tv === 1'b1) cmp("tx_ind", tq.pop_front(), {10'h0, ti});
		if (rv === 1'b1) cmp("rx_ind", xq.pop_front(), {12'h0, ri});
		if (hlt === 1'b1) cmp("halt_ring", hq.pop_front(), {13'h0, hring});
		if (txa === 1'b1) na++;
		if (txe === 1'b1) ne++;
		rd_seen <= rd_s;
		cyc++;
		if (cyc == 5000) begin
			errors++;
			end_of_test;
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'h0410e539));
		r = 3'($urandom);
		ridx = r;
		repeat (20) @(posedge clk);
		rst <= 0;
		rd(5'h08, 16'h0FFF, 0);
		rd(5'h10 + r, 16'h0000, 0);
		hq.push_back(r);
		pulse(11'h001);
		rd(5'h00, 16'h0003, 0);
		rd(5'h10 + r, 16'h0006, 0);
		wr(5'h00, 16'h0003, 0);
		rd(5'h00, 16'h0000, 0);
		wr(5'h07, 16'h0010 | r, 0);
		rd(5'h10 + r, 16'h0001, 0);
		cmp("ready", 16'h1, {15'h0, rdy[r]});
		hq.push_back(r);
		pulse(11'h004);
		rd(5'h10 + r, 16'h000A, 0);
		hq.push_back(r);
		pulse(11'h002);
		rd(5'h00, 16'h0003, 0);
		wr(5'h05, 16'h0000 | r, 0);
		wr(5'h06, 16'h0002, 0);
		rd(5'h10 + r, 16'h0000, 0);
		wr(5'h07, 16'h0010 | r, 0);
		wr(5'h05, 16'h0007, 1);
		wr(5'h06, 16'h0001, 0);
		rd(5'h10 + r, 16'h0001, 0);
		wr(5'h06, 16'h0001, 0);
		rd(5'h10 + r, 16'h0000, 0);
		wr(5'h01, 16'h0004, 0);
		repeat (3) @(posedge clk);
		cmp("irq", 16'h1, {15'h0, irq});
		wr(5'h01, 16'h003F, 1);
		rd(5'h01, 16'h0004, 0);
		rd(5'h00, 16'h0000, 1);
		rd(5'h00, 16'h0007, 0);
		wr(5'h00, 16'h0007, 0);
		repeat (3) @(posedge clk);
		cmp("irq", 16'h0, {15'h0, irq});
		pulse(11'h7F8);
		rd(5'h00, 16'h0038, 0);
		rd(5'h02, 16'h0001, 0);
		rd(5'h04, 16'h000F, 0);
		wr(5'h00, 16'h0038, 0);
		rd(5'h00, 16'h0000, 0);
		rd(5'h1F, 16'h0000, 0);
		for (int i = 0; i < 5; i++) begin
			tq.push_back(te[i]);
			@(posedge clk);
			mode <= 3'(i);
			go <= 1;
			@(posedge clk);
			go <= 0;
			repeat (5) @(posedge clk);
		end
		cmp("aborts", 16'd2, 16'(na));
		// Four bad frames, each marked from the fault until its end
		cmp("err_frame_cycles", 16'd8, 16'(ne));
		wm = 12'($urandom % 4000) + 12'd1;
		wr(5'h08, {4'h0, wm}, 0);
		rxe(4'b1001, 12'h000, 4'h0, 0);
		rxe(4'b0101, 12'h000, 4'h4, 1);
		rxe(4'b0011, wm, 4'h0, 0);
		rxe(4'b0011, wm + 12'd1, 4'h2, 1);
		wr(5'h08, {4'h8, wm}, 0);
		rxe(4'b1001, 12'h000, 4'h8, 1);
		repeat (4) @(posedge clk);
		cmp("left", 16'h0, 16'(rq.size() + tq.size() + xq.size()));
		cmp("halts_left", 16'h0, 16'(hq.size()));
		end_of_test;
	end
endmodule
